// ### rtl/converter_voltage_code_regs.sv
// register bank holding target voltage codes for converters four to six
`timescale 1ns/1ns
// Overview of operation
// - converter four sleep code, bits 7:1, read/write
// - converter five normal code, bits 7:1, read/write
// - converter five sleep code, bits 7:1, read/write
// - converter six normal code, bits 7:1, read/write
// - fall select 0: actively slew down
// - fall select 1: passive decay down
// - code uses fixed 10 or 25 mV steps
// - reset contents come from factory configuration
module converter_voltage_code_regs
   import conv_code_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // factory configuration, loaded once after reset release
   input wire logic [7:0] factory_conv4_sleep_i,
   input wire logic [7:0] factory_conv5_normal_i,
   input wire logic [7:0] factory_conv5_sleep_i,
   input wire logic [7:0] factory_conv6_normal_i,
   input wire logic [2:0] factory_step_25mv_i,
   // register access from the serial control port
   input wire reg_req_s req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic loaded_o,
   // targets to the converters
   input wire logic [2:0] sleep_active_i,
   output conv_target_s conv4_target_o,
   output conv_target_s conv5_target_o,
   output conv_target_s conv6_target_o,
   output logic [2:0] active_slew_down_o
);

   // =========================================================
   // factory load: caught by the first clock edge after release
   logic load_pend_r;
   logic [2:0] step_r;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_pend_r <= 1'b1;
      end else begin
         load_pend_r <= 1'b0;
      end
   end

   // loaded stays up until the next reset
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         loaded_o <= 1'b0;
      end else if (load_pend_r) begin
         loaded_o <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         step_r <= 3'h0;
      end else if (load_pend_r) begin
         step_r <= factory_step_25mv_i;
      end
   end

   // =========================================================
   // register cells
   logic [7:0] load_val [NUM_REGS];
   logic [7:0] mask [NUM_REGS];
   logic [7:0] ofs [NUM_REGS];
   logic [7:0] value [NUM_REGS];
   always_comb begin
      load_val[0] = factory_conv4_sleep_i;
      load_val[1] = factory_conv5_normal_i;
      load_val[2] = factory_conv5_sleep_i;
      load_val[3] = factory_conv6_normal_i;
      mask[0] = SLEEP_WRITE_MASK;
      mask[1] = NORMAL_WRITE_MASK;
      mask[2] = SLEEP_WRITE_MASK;
      mask[3] = NORMAL_WRITE_MASK;
      ofs[0] = OFS_CONV4_SLEEP_TARGET;
      ofs[1] = OFS_CONV5_NORMAL_TARGET;
      ofs[2] = OFS_CONV5_SLEEP_TARGET;
      ofs[3] = OFS_CONV6_NORMAL_TARGET;
   end

   // =========================================================
   // address decode, shared by the write strobes and the read mux
   logic [NUM_REGS-1:0] hit;
   always_comb begin
      hit = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         hit[i] = (req_i.addr == ofs[i]);
      end
   end

   // a write in the load cycle loses; software cannot race the factory image
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_cell
      conv_code_cell u_cell (
         .core_clk_i(core_clk_i),
         .resetn_i(resetn_i),
         .load_i(load_pend_r),
         .load_val_i(load_val[g]),
         .wr_i(req_i.wr && hit[g]),
         .wdata_i(req_i.wdata),
         .mask_i(mask[g]),
         .value_o(value[g])
      );
   end

   // =========================================================
   // read path
   logic [7:0] rdata_nxt;
   always_comb begin
      rdata_nxt = READ_UNMAPPED;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i]) begin
            rdata_nxt = value[i];
         end
      end
   end

   // read data holds the last answer until the next read
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else if (req_i.rd) begin
         rdata_o <= rdata_nxt;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
      end
   end

   // =========================================================
   // field views of the stored bytes
   logic [CODE_W-1:0] conv4_sleep_code;
   logic [CODE_W-1:0] conv5_normal_code;
   logic [CODE_W-1:0] conv5_sleep_code;
   logic [CODE_W-1:0] conv6_normal_code;
   logic conv5_passive_fall_sel;
   logic conv6_passive_fall_sel;
   logic [CODE_W-1:0] conv5_code_sel;
   always_comb begin
      conv4_sleep_code = value[0][CODE_MSB:CODE_LSB];
      conv5_normal_code = value[1][CODE_MSB:CODE_LSB];
      conv5_sleep_code = value[2][CODE_MSB:CODE_LSB];
      conv6_normal_code = value[3][CODE_MSB:CODE_LSB];
      conv5_passive_fall_sel = value[1][FALL_SEL_BIT];
      conv6_passive_fall_sel = value[3][FALL_SEL_BIT];
   end

   // sleep request for converter five swaps in its sleep code
   always_comb begin
      conv5_code_sel = conv5_normal_code;
      if (sleep_active_i[1]) begin
         conv5_code_sel = conv5_sleep_code;
      end
   end

   // =========================================================
   // converter targets
   // converter four normal code lives outside this bank, so its code shows the sleep target only
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv4_target_o <= '0;
      end else begin
         conv4_target_o.code <= conv4_sleep_code;
         conv4_target_o.passive_fall_sel <= 1'b0;
         conv4_target_o.step_25mv <= step_r[0];
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv5_target_o <= '0;
      end else begin
         conv5_target_o.code <= conv5_code_sel;
         conv5_target_o.passive_fall_sel <= conv5_passive_fall_sel;
         conv5_target_o.step_25mv <= step_r[1];
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv6_target_o <= '0;
      end else begin
         conv6_target_o.code <= conv6_normal_code;
         conv6_target_o.passive_fall_sel <= conv6_passive_fall_sel;
         conv6_target_o.step_25mv <= step_r[2];
      end
   end

   // =========================================================
   // active pull-down enable while falling toward a lower code
   // converter four has no fall select here, so it always slews actively
   logic [2:0] slew_nxt;
   always_comb begin
      slew_nxt[0] = 1'b1;
      slew_nxt[1] = ~conv5_passive_fall_sel;
      slew_nxt[2] = ~conv6_passive_fall_sel;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         active_slew_down_o <= 3'h0;
      end else begin
         active_slew_down_o <= slew_nxt;
      end
   end

endmodule // converter_voltage_code_regs

// ### shared/conv_code_pkg.sv
// shared constants and carriers for the converter voltage-code register bank
package conv_code_pkg;

   // =========================================================
   // register offsets on the serial control port
   localparam logic [7:0] OFS_CONV4_SLEEP_TARGET = 8'h95;
   localparam logic [7:0] OFS_CONV5_NORMAL_TARGET = 8'h96;
   localparam logic [7:0] OFS_CONV5_SLEEP_TARGET = 8'h97;
   localparam logic [7:0] OFS_CONV6_NORMAL_TARGET = 8'h98;

   // =========================================================
   // field layout
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 1;
   localparam int FALL_SEL_BIT = 0;
   localparam int CODE_W = 7;
   localparam int NUM_REGS = 4;
   localparam logic [7:0] SLEEP_WRITE_MASK = 8'hFE;
   localparam logic [7:0] NORMAL_WRITE_MASK = 8'hFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // =========================================================
   // step range options
   localparam logic STEP_10MV = 1'b0;
   localparam logic STEP_25MV = 1'b1;

   // =========================================================
   // carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic passive_fall_sel;
      logic step_25mv;
   } conv_target_s;

endpackage

// ### rtl/conv_code_cell.sv
// one 8-bit target register cell with factory-loaded reset and write mask
`timescale 1ns/1ns
module conv_code_cell
   import conv_code_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // factory load
   input wire logic load_i,
   input wire logic [7:0] load_val_i,
   // write port
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] mask_i,
   // contents
   output logic [7:0] value_o
);

   // =========================================================
   // storage
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_o <= 8'h00;
      end else if (load_i) begin
         value_o <= load_val_i & mask_i;
      end else if (wr_i) begin
         value_o <= wdata_i & mask_i;
      end
   end

endmodule // conv_code_cell

// ### sim/conv_code_sva.sv
// assertion checker for the converter voltage-code register bank
`timescale 1ns/1ns
module conv_code_sva
   import conv_code_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire reg_req_s req_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic loaded_o,
   input wire conv_target_s conv5_target_o,
   input wire conv_target_s conv6_target_o,
   input wire logic [2:0] active_slew_down_o
);
   // ====
   // properties
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_map_rd;
      req_i.rd && req_i.addr inside {[8'h95:8'h98]};
   endsequence
   sequence s_wr_six;
      req_i.wr && loaded_o && req_i.addr == OFS_CONV6_NORMAL_TARGET;
   endsequence
   a_read_answer: assert property (s_map_rd |=> rvalid_o)
      else $error("read not answered");
   a_valid_cause: assert property (rvalid_o |-> $past(req_i.rd))
      else $error("answer without read");
   a_unmapped_zero: assert property (req_i.rd && !(req_i.addr inside {[8'h95:8'h98]})
      |=> rdata_o == READ_UNMAPPED) else $error("unmapped read not zero");
   a_sleep_lsb: assert property (req_i.rd && req_i.addr inside {8'h95, 8'h97} |=> !rdata_o[0])
      else $error("reserved bit not zero");
   a_slew_five: assert property (loaded_o |-> active_slew_down_o[1] != conv5_target_o.passive_fall_sel)
      else $error("fall mode five wrong");
   a_slew_six: assert property (loaded_o |-> active_slew_down_o[2] != conv6_target_o.passive_fall_sel)
      else $error("fall mode six wrong");
   a_wr_target: assert property (s_wr_six |-> ##2 conv6_target_o.code == $past(req_i.wdata[7:1], 2))
      else $error("six target not updated");
   a_load_time: assert property ($rose(resetn_i) |-> ##2 loaded_o)
      else $error("factory load late");
   a_step_fixed: assert property (loaded_o && $past(loaded_o, 2)
      |-> $stable(conv5_target_o.step_25mv) && $stable(conv6_target_o.step_25mv)) else $error("step range changed");
endmodule // conv_code_sva
bind converter_voltage_code_regs conv_code_sva i_sva (.core_clk_i, .resetn_i, .req_i, .rdata_o, .rvalid_o,
   .loaded_o, .conv5_target_o, .conv6_target_o, .active_slew_down_o);

// ### sim/ctrl_host.sv
// host model issuing register requests on the serial control side
`timescale 1ns/1ns
module ctrl_host
   import conv_code_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output reg_req_s req_o
);
   // ====
   // access tasks, each leaves an idle edge so no signal is driven twice in one step
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req_o <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk_i);
      req_o <= '0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      req_o <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk_i);
      req_o <= '0;
      d = 8'hXX;
      for (n = 0; n < 4; n++) begin
         @(posedge core_clk_i);
         if (rvalid_i === 1'b1) break;
      end
      d = rdata_i;
      if (n == 4) begin
         converter_voltage_code_regs_bench.fails++;
         converter_voltage_code_regs_bench.conclude();
      end
   endtask
endmodule // ctrl_host

// ### sim/converter_voltage_code_regs_bench.sv
// self-checking bench for the converter voltage-code register bank
`timescale 1ns/1ns
module converter_voltage_code_regs_bench;
   import conv_code_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   reg_req_s req;
   logic [7:0] rdata, d;
   logic rvalid, loaded;
   logic [2:0] sleep_act = 3'h0, slew;
   conv_target_s t4, t5, t6;
   logic [7:0] fac [4] = '{8'hA5, 8'h3C, 8'h5B, 8'hC3};
   logic [7:0] msk [4] = '{SLEEP_WRITE_MASK, NORMAL_WRITE_MASK, SLEEP_WRITE_MASK, NORMAL_WRITE_MASK};
   int fails = 0, num_checks = 0;
   always #50 clk = ~clk;
   converter_voltage_code_regs i_dut (.core_clk_i(clk), .resetn_i(resetn), .factory_conv4_sleep_i(fac[0]),
      .factory_conv5_normal_i(fac[1]), .factory_conv5_sleep_i(fac[2]), .factory_conv6_normal_i(fac[3]),
      .factory_step_25mv_i(3'h5), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .loaded_o(loaded),
      .sleep_active_i(sleep_act), .conv4_target_o(t4), .conv5_target_o(t5), .conv6_target_o(t6),
      .active_slew_down_o(slew));
   ctrl_host i_host (.core_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
   // ====
   // checking and closing
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check("loaded", {7'h00, loaded}, 8'h01);
      for (int i = 0; i < NUM_REGS; i++) begin
         i_host.rd(OFS_CONV4_SLEEP_TARGET + 8'(i), d);
         check("reset image", d, fac[i] & msk[i]);
         i_host.wr(OFS_CONV4_SLEEP_TARGET + 8'(i), 8'hFF);
         i_host.rd(OFS_CONV4_SLEEP_TARGET + 8'(i), d);
         check("ones", d, msk[i]);
         i_host.wr(OFS_CONV4_SLEEP_TARGET + 8'(i), 8'h00);
         i_host.rd(OFS_CONV4_SLEEP_TARGET + 8'(i), d);
         check("zeros", d, 8'h00);
      end
      check("four code", {1'b0, t4.code}, 8'h00);
      check("four slew", {6'h00, t4.passive_fall_sel, slew[0]}, 8'h01);
      check("steps", {5'h00, t6.step_25mv, t5.step_25mv, t4.step_25mv}, 8'h05);
      i_host.wr(OFS_CONV5_NORMAL_TARGET, 8'hAB);
      repeat (2) @(posedge clk);
      check("five code", {1'b0, t5.code}, 8'h55);
      check("five passive", {7'h00, slew[1]}, 8'h00);
      check("five fall sel", {7'h00, t5.passive_fall_sel}, 8'h01);
      i_host.wr(OFS_CONV5_NORMAL_TARGET, 8'hAA);
      repeat (2) @(posedge clk);
      check("five active", {7'h00, slew[1]}, 8'h01);
      i_host.wr(OFS_CONV5_SLEEP_TARGET, 8'h64);
      sleep_act <= 3'h2;
      repeat (2) @(posedge clk);
      check("five sleep", {1'b0, t5.code}, 8'h32);
      i_host.wr(8'h99, 8'hFF);
      i_host.rd(8'h94, d);
      check("unmapped", d, READ_UNMAPPED);
      i_host.rd(OFS_CONV6_NORMAL_TARGET, d);
      check("six kept", d, 8'h00);
      i_host.wr(OFS_CONV6_NORMAL_TARGET, 8'h81);
      repeat (2) @(posedge clk);
      check("six code", {1'b0, t6.code}, 8'h40);
      check("six passive", {6'h00, t6.passive_fall_sel, slew[2]}, 8'h02);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check("reloaded", {7'h00, loaded}, 8'h01);
      i_host.rd(OFS_CONV6_NORMAL_TARGET, d);
      check("six reload", d, fac[3]);
      conclude();
   end
endmodule // converter_voltage_code_regs_bench
